// >>> logic/stc_consts.svh
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH
`define STC_ADDR_CTRL 12'h000
`define STC_ADDR_STAT 12'h004
`define STC_ADDR_PER 12'h008
`define STC_ADDR_TRK 12'h00C
`define STC_CTRL_RST 9'h000
`define STC_PER_RST 16'h0064
`define STC_CB_SMODE 0
`define STC_CB_DITH 2
`define STC_CB_DTX 3
`define STC_CB_FDT 4
`define STC_CB_DRV 5
`define STC_CB_USLP 7
`define STC_CB_ATRK 8
`define STC_CLK_MHZ 40
`define STC_DT_MIN_NS 75
`define STC_DT_EXT_NS 15
`define STC_DT_MIN_CYC 4'((`STC_DT_MIN_NS * `STC_CLK_MHZ + 999) / 1000)
`define STC_DT_EXT_CYC 4'((`STC_DT_EXT_NS * `STC_CLK_MHZ + 999) / 1000)
`define STC_FAST_PER 16'h0028
`define STC_PROBE_CYC 12'h800
`define STC_TRK_EDGE_MIN 7'h04
`define STC_TRK_EDGE_MAX 7'h40
`define STC_TRI_MAX 6'sh10
`endif

// >>> logic/stc_pkg.sv
package stc_pkg;
   typedef enum logic [1:0] {
      SYNC_RISE = 2'h0,
      SYNC_FALL = 2'h1,
      SYNC_OUT = 2'h2,
      SYNC_OUT_ALT = 2'h3
   } stc_sync_mode_type;
   typedef enum logic [1:0] {
      DRV_OPEN_DRAIN = 2'h0,
      DRV_PP_OUTPUT = 2'h1,
      DRV_PP_BIAS = 2'h2,
      DRV_CHARGE_PUMP = 2'h3
   } stc_drv_mode_type;
   typedef enum logic [4:0] {
      GS_OFF = 5'h01,
      GS_LO = 5'h02,
      GS_DT_HI = 5'h04,
      GS_HI = 5'h08,
      GS_DT_LO = 5'h10
   } stc_gate_state_type;
   // Asynchronous pin levels, each resynchronised
   typedef struct packed {
      logic sync;
      logic pwm_tracking_input;
      logic pwm_tracking_input_above;
      logic mode;
      logic en_ok;
      logic aux_ok;
      logic hiccup;
      logic tsd;
      logic bst_ok;
      logic bst_clamp;
      logic ss_above_ref;
      logic psm;
      logic usleep;
      logic rst_pin;
      logic strap_dtx;
      logic [1:0] lo_low;
      logic [1:0] ho_low;
   } stc_pins_type;
   // Same-clock demands from the modulator
   typedef struct packed {
      logic [1:0] pwm_hi;
      logic buck;
      logic boost;
      logic [7:0] duty;
   } stc_mod_type;
endpackage

// >>> logic/stc_top.sv
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "stc_consts.svh"
// Overview of operation
// - Lock to sync within 50%, else resistor
// - Invalid sync frequency turns input buffer off
// - No sync following in power save/micro-sleep
// - Relock to sync pin after returning
// - Sync pin: rising, falling, or clock out
// - Analog-track start: mode edge ends soft start
// - Digital tracking needs threshold and valid PWM
// - Reference scales with duty, capped at nominal
// - Discharge soft start on five disable causes
// - Soft start done above reference, use reference
// - Disconnect driver has four supply configurations
// - Dither only when enabled, never while synced
// - Triangular plus random frequency modulation
// - Triangle rate itself varies at random
// - On-time rescaled every cycle while dithering
// - Buck/boost holds idle bridge high side on
// - Dead time and gate-low check before switching
// - Bootstrap undervoltage stops, restarts via soft start
// - Bootstrap overvoltage enables pull-down source
// - Dead-time extension adds one 25 ns cycle (15 ns rounded up)
// - Extension from strap pin or register
// - Register option shortens dead time when fast
// - Strap sampled once, held until reset/undervoltage
module stc_top (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input stc_pkg::stc_pins_type i_pins,
   input stc_pkg::stc_mod_type i_mod,
   output logic o_sync_o,
   output logic o_sync_oe,
   output logic o_sync_buf_en,
   output logic o_sw_clk,
   output logic [15:0] o_on_time,
   output logic [9:0] o_ref_scale,
   output logic o_ss_use_ref,
   output logic o_ss_discharge,
   output logic o_sw_en,
   output logic [1:0] o_ho,
   output logic [1:0] o_lo,
   output logic o_bst_pulldown,
   output stc_pkg::stc_drv_mode_type o_drv_mode
);
   localparam int NP = $bits(stc_pkg::stc_pins_type);
   logic [NP-1:0] s1, s2, s3, pf;
   stc_pkg::stc_pins_type p;
   logic [8:0] ctrl;
   logic [15:0] center;
   stc_pkg::stc_sync_mode_type smode;
   logic sync_d, sync_in, sync_edge, hold, have_edge, sync_valid, sync_bad;
   logic [16:0] sync_cnt;
   logic [15:0] sync_meas;
   logic [11:0] probe_cnt;
   logic [15:0] osc_cnt, per_cur, next_per;
   logic cyc_end;
   logic [15:0] lfsr;
   logic signed [5:0] tri_val;
   logic tri_up;
   logic [1:0] tri_div;
   logic dith_on;
   logic signed [6:0] mod_v;
   logic signed [23:0] dprod;
   logic [9:0] win_cnt;
   logic [10:0] hi_cnt;
   logic [6:0] edge_cnt;
   logic pwm_tracking_input_d, trk_ok, trk_active;
   logic [9:0] trk_scale;
   logic fault, ss_done, mode_d;
   logic rst_d, latched, dtx_strap;
   logic [3:0] dt_cyc;

   // Three-stage resynchroniser, value taken when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_sync
         always_ff @(posedge i_ref_clk) begin
            if (i_sys_rst) begin
               s1[gi] <= 1'b0;
               s2[gi] <= 1'b0;
               s3[gi] <= 1'b0;
               pf[gi] <= 1'b0;
            end else begin
               s1[gi] <= i_pins[gi];
               s2[gi] <= s1[gi];
               s3[gi] <= s2[gi];
               if (s2[gi] == s3[gi]) begin
                  pf[gi] <= s3[gi];
               end
            end
         end
      end
   endgenerate
   assign p = pf;

   // APB slave, zero wait states, data sampled in setup phase
   assign o_pready = i_psel & i_penable;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (i_psel && !i_penable) begin
         o_pslverr <= 1'b0;
         unique case (i_paddr)
            `STC_ADDR_CTRL: o_prdata <= {23'h00_0000, ctrl};
            `STC_ADDR_STAT: o_prdata <= {24'h00_0000, trk_active, ss_done, o_sw_en,
               sync_valid, o_sync_buf_en, dtx_strap, latched, o_bst_pulldown};
            `STC_ADDR_PER: o_prdata <= {16'h0000, center};
            `STC_ADDR_TRK: o_prdata <= {6'h00, trk_scale, sync_meas};
            default: begin
               o_prdata <= 32'h0000_0000;
               o_pslverr <= 1'b1;
            end
         endcase
      end
   end

   // Register writes at the access edge
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ctrl <= `STC_CTRL_RST;
         center <= `STC_PER_RST;
      end else if (i_psel && i_penable && i_pwrite) begin
         if (i_paddr == `STC_ADDR_CTRL) begin
            ctrl <= i_pwdata[8:0];
         end
         if (i_paddr == `STC_ADDR_PER) begin
            center <= i_pwdata[15:0];
         end
      end
   end
   assign smode = stc_pkg::stc_sync_mode_type'(ctrl[`STC_CB_SMODE+:2]);
   assign o_drv_mode = stc_pkg::stc_drv_mode_type'(ctrl[`STC_CB_DRV+:2]);

   // Sync pin direction and edge choice
   assign o_sync_oe = smode[1];
   assign o_sync_o = smode[1] & o_sw_clk;
   assign sync_in = p.sync & o_sync_buf_en & ~smode[1];
   assign sync_edge = (smode == stc_pkg::SYNC_FALL) ? (sync_d & ~sync_in) :
      (~sync_d & sync_in);
   assign hold = p.psm | (p.usleep & ctrl[`STC_CB_USLP]);
   // Period out of the +-50 % frequency window, or no edge at all
   assign sync_bad = (sync_edge && have_edge &&
      ((18'({1'b0, sync_cnt}) * 18'h0_0003 < {1'b0, center, 1'b0}) ||
      (sync_cnt > {center, 1'b0}))) || (sync_cnt > {center, 1'b0});

   // Period measurement, lock state and buffer power
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         sync_d <= 1'b0;
         sync_cnt <= 17'h0_0000;
         sync_meas <= 16'h0000;
         have_edge <= 1'b0;
         sync_valid <= 1'b0;
         o_sync_buf_en <= 1'b1;
         probe_cnt <= 12'h000;
      end else begin
         sync_d <= sync_in;
         if (hold || smode[1]) begin
            sync_valid <= 1'b0;
            have_edge <= 1'b0;
            sync_cnt <= 17'h0_0000;
         end else if (!o_sync_buf_en) begin
            probe_cnt <= probe_cnt - 12'h001;
            if (probe_cnt == 12'h000) begin
               o_sync_buf_en <= 1'b1;
               sync_cnt <= 17'h0_0000;
            end
         end else if (sync_bad) begin
            o_sync_buf_en <= 1'b0;
            probe_cnt <= `STC_PROBE_CYC;
            sync_valid <= 1'b0;
            have_edge <= 1'b0;
         end else if (sync_edge) begin
            have_edge <= 1'b1;
            sync_valid <= have_edge;
            sync_meas <= sync_cnt[15:0];
            sync_cnt <= 17'h0_0001;
         end else begin
            sync_cnt <= sync_cnt + 17'h0_0001;
         end
      end
   end

   // Spread-spectrum modulation terms
   // Buffer power-down must not stop dithering while no sync source is fitted
   assign dith_on = ctrl[`STC_CB_DITH] & ~sync_valid;
   assign mod_v = 7'(tri_val) + 7'($signed({1'b0, lfsr[2:0]}) - 7'sh04);
   assign dprod = $signed({8'h00, center}) * 24'(mod_v);
   always_comb begin
      if (sync_valid) begin
         next_per = sync_meas;
      end else if (dith_on) begin
         next_per = 16'(center + dprod[22:7]);
      end else begin
         next_per = center;
      end
   end

   // Random sequence and triangle with random step rate
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         lfsr <= 16'hACE1;
         tri_val <= 6'sh00;
         tri_up <= 1'b1;
         tri_div <= 2'h0;
      end else if (cyc_end) begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         tri_div <= tri_div - 2'h1;
         if (tri_div == 2'h0) begin
            tri_div <= lfsr[5:4];
            if (tri_up) begin
               tri_val <= tri_val + 6'sh01;
               tri_up <= tri_val < `STC_TRI_MAX - 6'sh01;
            end else begin
               tri_val <= tri_val - 6'sh01;
               tri_up <= tri_val <= -`STC_TRI_MAX + 6'sh01;
            end
         end
      end
   end

   // Switching clock, phase-aligned to sync edges when locked
   assign cyc_end = (osc_cnt + 16'h0001 >= per_cur) | (sync_valid & sync_edge);
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         osc_cnt <= 16'h0000;
         per_cur <= `STC_PER_RST;
         o_sw_clk <= 1'b0;
         o_on_time <= 16'h0000;
      end else begin
         if (cyc_end) begin
            osc_cnt <= 16'h0000;
            per_cur <= next_per;
            o_on_time <= 16'((24'(next_per) * 24'(i_mod.duty)) >> 8);
         end else begin
            osc_cnt <= osc_cnt + 16'h0001;
         end
         o_sw_clk <= cyc_end | (osc_cnt + 16'h0001 < {1'b0, per_cur[15:1]});
      end
   end

   // Digital tracking: duty and edge count over a fixed window
   assign trk_active = trk_ok & p.pwm_tracking_input_above;
   assign o_ref_scale = trk_active ? trk_scale : 10'h3FF;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         win_cnt <= 10'h000;
         hi_cnt <= 11'h000;
         edge_cnt <= 7'h00;
         pwm_tracking_input_d <= 1'b0;
         trk_ok <= 1'b0;
         trk_scale <= 10'h3FF;
      end else begin
         pwm_tracking_input_d <= p.pwm_tracking_input;
         win_cnt <= win_cnt + 10'h001;
         if (win_cnt == 10'h3FF) begin
            trk_ok <= p.pwm_tracking_input_above && edge_cnt >= `STC_TRK_EDGE_MIN &&
               edge_cnt <= `STC_TRK_EDGE_MAX;
            trk_scale <= hi_cnt[10] ? 10'h3FF : hi_cnt[9:0];
            hi_cnt <= 11'h000;
            edge_cnt <= 7'h00;
         end else begin
            hi_cnt <= hi_cnt + {10'h000, p.pwm_tracking_input};
            if (p.pwm_tracking_input && !pwm_tracking_input_d && edge_cnt != 7'h7F) begin
               edge_cnt <= edge_cnt + 7'h01;
            end
         end
      end
   end

   // Soft start, disable causes and bootstrap protection
   assign fault = ~p.en_ok | ~p.aux_ok | p.hiccup | p.tsd | ~p.bst_ok;
   assign o_ss_use_ref = ss_done;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_ss_discharge <= 1'b1;
         o_sw_en <= 1'b0;
         ss_done <= 1'b0;
         mode_d <= 1'b0;
         o_bst_pulldown <= 1'b0;
      end else begin
         mode_d <= p.mode;
         o_ss_discharge <= fault;
         o_sw_en <= ~fault;
         o_bst_pulldown <= p.bst_clamp;
         if (fault) begin
            ss_done <= 1'b0;
         end else if (p.ss_above_ref) begin
            ss_done <= 1'b1;
         end else if (ctrl[`STC_CB_ATRK] && (p.mode != mode_d)) begin
            ss_done <= 1'b1;
         end
      end
   end

   // Strap latch, released by reset pin toggle or aux undervoltage
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         rst_d <= 1'b0;
         latched <= 1'b0;
         dtx_strap <= 1'b0;
      end else begin
         rst_d <= p.rst_pin;
         if ((p.rst_pin != rst_d) || !p.aux_ok) begin
            latched <= 1'b0;
         end else if (!latched) begin
            latched <= 1'b1;
            dtx_strap <= p.strap_dtx;
         end
      end
   end

   // Dead-time count in reference cycles
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         dt_cyc <= `STC_DT_MIN_CYC;
      end else begin
         dt_cyc <= `STC_DT_MIN_CYC
            + ((dtx_strap | ctrl[`STC_CB_DTX]) ? `STC_DT_EXT_CYC : 4'h0)
            - ((ctrl[`STC_CB_FDT] && center <= `STC_FAST_PER) ? 4'h1 : 4'h0);
      end
   end

   // Per-bridge gate sequencer with shoot-through protection
   generate
      for (gi = 0; gi < 2; gi++) begin : g_bridge
         stc_pkg::stc_gate_state_type st;
         logic [3:0] cnt;
         logic want_hi;
         assign want_hi = (gi == 0) ? (i_mod.boost | (~i_mod.buck & i_mod.pwm_hi[gi])) :
            (i_mod.buck | (~i_mod.boost & i_mod.pwm_hi[gi]));
         assign o_ho[gi] = (st == stc_pkg::GS_HI);
         assign o_lo[gi] = (st == stc_pkg::GS_LO);
         always_ff @(posedge i_ref_clk) begin
            if (i_sys_rst) begin
               st <= stc_pkg::GS_OFF;
               cnt <= 4'h0;
            end else if (!o_sw_en) begin
               st <= stc_pkg::GS_OFF;
               cnt <= 4'h0;
            end else begin
               cnt <= cnt + 4'h1;
               unique case (st)
                  stc_pkg::GS_OFF, stc_pkg::GS_LO, stc_pkg::GS_HI: begin
                     cnt <= 4'h0;
                     if (want_hi && st != stc_pkg::GS_HI) begin
                        st <= stc_pkg::GS_DT_HI;
                     end else if (!want_hi && st != stc_pkg::GS_LO) begin
                        st <= stc_pkg::GS_DT_LO;
                     end
                  end
                  stc_pkg::GS_DT_HI: begin
                     if (!want_hi) begin
                        st <= stc_pkg::GS_DT_LO;
                        cnt <= 4'h0;
                     end else if (cnt + 4'h1 >= dt_cyc && p.lo_low[gi]) begin
                        st <= stc_pkg::GS_HI;
                     end
                  end
                  stc_pkg::GS_DT_LO: begin
                     if (want_hi) begin
                        st <= stc_pkg::GS_DT_HI;
                        cnt <= 4'h0;
                     end else if (cnt + 4'h1 >= dt_cyc && p.ho_low[gi]) begin
                        st <= stc_pkg::GS_LO;
                     end
                  end
               endcase
            end
         end
      end
   endgenerate

   // Checks on the design's own outputs
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_fault;
      fault;
   endsequence
   sequence s_buck_steady;
      (o_sw_en && i_mod.buck && !i_mod.boost)[*8];
   endsequence
   no_shoot_thru_a: assert property (!(o_ho[0] && o_lo[0]) && !(o_ho[1] && o_lo[1]))
      else $error("high and low gate on together");
   dead_gap_a: assert property ($rose(o_ho[0]) |-> !$past(o_lo[0]) && !$past(o_lo[0], 2))
      else $error("high gate on without dead gap");
   buck_hold_a: assert property (s_buck_steady |-> !o_lo[1])
      else $error("idle bridge low side on in buck");
   ss_discharge_a: assert property (s_fault |=> o_ss_discharge && !o_sw_en ##1 !o_ho[0])
      else $error("no discharge after disable cause");
   ss_finish_a: assert property (p.ss_above_ref && !fault |=> o_ss_use_ref)
      else $error("soft start not ended above reference");
   dither_sync_a: assert property (sync_valid |-> next_per == sync_meas)
      else $error("dither or resistor period while synced");
   hold_unlock_a: assert property (hold |=> !sync_valid)
      else $error("sync followed during power save");
   buf_off_a: assert property (o_sync_buf_en && sync_bad && !hold && !smode[1]
      |=> !o_sync_buf_en ##1 !o_sync_buf_en)
      else $error("sync buffer kept on for bad frequency");
   ref_cap_a: assert property (!trk_active |-> o_ref_scale == 10'h3FF)
      else $error("reference scaled without tracking");
   clamp_pd_a: assert property (p.bst_clamp |=> o_bst_pulldown)
      else $error("pull-down not enabled on clamp");
   sync_out_a: assert property (smode[1] |-> o_sync_oe && (o_sync_o == o_sw_clk))
      else $error("sync pin not driving oscillator clock");
endmodule // stc_top

// >>> test/stc_partner.sv
`timescale 1ns/100ps
// Far side: sync source, tracking PWM source and gate voltage feedback
module stc_partner (
   input wire logic i_clk,
   input wire logic [15:0] i_sync_per,
   input wire logic [15:0] i_trk_per,
   input wire logic [15:0] i_trk_hi,
   input wire logic i_stuck,
   input wire logic [1:0] i_ho,
   input wire logic [1:0] i_lo,
   output logic o_sync,
   output logic o_pwm_tracking_input,
   output logic [1:0] o_lo_low,
   output logic [1:0] o_ho_low
);
   logic [15:0] sc = 16'h0000;
   logic [15:0] tc = 16'h0000;
   logic [1:0] ho_q = 2'b00;
   logic [1:0] lo_q = 2'b00;
   // Period counters, held at zero while the source is off
   always @(posedge i_clk) begin
      sc <= (i_sync_per == 16'h0000 || sc + 16'h0001 >= i_sync_per) ? 16'h0000 : sc + 16'h0001;
      tc <= (i_trk_per == 16'h0000 || tc + 16'h0001 >= i_trk_per) ? 16'h0000 : tc + 16'h0001;
      ho_q <= i_ho;
      lo_q <= i_lo;
   end
   // Sync line stands low when no source is fitted
   assign o_sync = (i_sync_per != 16'h0000) && (sc < (i_sync_per >> 1));
   assign o_pwm_tracking_input = (i_trk_per != 16'h0000) && (tc < i_trk_hi);
   // Gate reads low one cycle after its command drops; stuck low side never discharges
   assign o_lo_low = i_stuck ? 2'b00 : ~(i_lo | lo_q);
   assign o_ho_low = ~(i_ho | ho_q);
endmodule // stc_partner

// >>> test/stc_top_tb.sv
`timescale 1ns/100ps
`include "stc_consts.svh"
module stc_top_tb;
   logic i_ref_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, o_sync_o, o_sync_oe, o_sync_buf_en, o_sw_clk;
   logic o_ss_use_ref, o_ss_discharge, o_sw_en, o_bst_pulldown, p_sync, p_pwm_tracking_input;
   logic [15:0] o_on_time;
   logic [9:0] o_ref_scale;
   logic [1:0] o_ho, o_lo, p_lo_low, p_ho_low;
   logic [1:0] ho_d = 2'b00;
   logic [1:0] lo_d = 2'b00;
   logic swc_d = 1'b0;
   logic stuck = 1'b0;
   stc_pkg::stc_drv_mode_type o_drv_mode;
   stc_pkg::stc_pins_type pins = '0;
   stc_pkg::stc_pins_type pins_w;
   stc_pkg::stc_mod_type mods = '0;
   logic [15:0] sync_per = 16'h0000;
   logic [15:0] trk_per = 16'h0000;
   logic [15:0] trk_hi = 16'h0000;
   logic [64:0] exp_q[$];
   logic [64:0] e;
   logic [31:0] v;
   int n_fail = 0, check_count = 0, seed = 49, dt_exp = 3, sw_edges = 0, s = 0;
   int lo_off[2] = '{0, 0};
   int ho_off[2] = '{0, 0};

   stc_top stc_top_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pins(pins_w),
      .i_mod(mods), .o_sync_o(o_sync_o), .o_sync_oe(o_sync_oe),
      .o_sync_buf_en(o_sync_buf_en), .o_sw_clk(o_sw_clk), .o_on_time(o_on_time),
      .o_ref_scale(o_ref_scale), .o_ss_use_ref(o_ss_use_ref),
      .o_ss_discharge(o_ss_discharge), .o_sw_en(o_sw_en), .o_ho(o_ho), .o_lo(o_lo),
      .o_bst_pulldown(o_bst_pulldown), .o_drv_mode(o_drv_mode));
   stc_partner stc_partner_i (.i_clk(i_ref_clk), .i_sync_per(sync_per), .i_trk_per(trk_per),
      .i_trk_hi(trk_hi), .i_stuck(stuck), .i_ho(o_ho), .i_lo(o_lo), .o_sync(p_sync),
      .o_pwm_tracking_input(p_pwm_tracking_input), .o_lo_low(p_lo_low), .o_ho_low(p_ho_low));

   // Pin bundle with far-side levels merged in
   always_comb begin
      pins_w = pins;
      pins_w.sync = p_sync;
      pins_w.pwm_tracking_input = p_pwm_tracking_input;
      pins_w.lo_low = p_lo_low;
      pins_w.ho_low = p_ho_low;
   end
   // Clock
   initial begin
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end

   task automatic chk(input string name, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, ex, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (n >= 50) chk("pready", 1, 0);
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdm(input logic [11:0] a, input logic [31:0] ex, input logic [31:0] m,
         input logic err);
      exp_q.push_back({err, m, ex});
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic fault(input int c, input logic f);
      case (c)
         0: pins.en_ok <= !f;
         1: pins.aux_ok <= !f;
         2: pins.hiccup <= f;
         3: pins.tsd <= f;
         default: pins.bst_ok <= !f;
      endcase
   endtask
   task automatic stop_test;
      if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Read results against the oldest note
   always @(posedge i_ref_clk) begin
      if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite) begin
         if (exp_q.size() == 0) chk("read_queue", 1, 0);
         else begin
            e = exp_q.pop_front();
            chk("prdata", e[31:0], o_prdata & e[63:32]);
            chk("pslverr", {31'h0, e[64]}, {31'h0, o_pslverr});
         end
      end
   end
   // Gate sequencing and switching clock edge count
   always @(posedge i_ref_clk) begin
      for (int b = 0; b < 2; b++) begin
         if (o_ho[b] & ~ho_d[b]) chk("dead_lo_hi", 1, 32'(lo_off[b] >= dt_exp));
         if (o_lo[b] & ~lo_d[b]) chk("dead_hi_lo", 1, 32'(ho_off[b] >= dt_exp));
         if (o_ho[b] & o_lo[b]) chk("overlap", 0, 1);
         lo_off[b] = o_lo[b] ? 0 : lo_off[b] + 1;
         ho_off[b] = o_ho[b] ? 0 : ho_off[b] + 1;
      end
      ho_d = o_ho;
      lo_d = o_lo;
      if (o_sw_clk && !swc_d) sw_edges++;
      swc_d = o_sw_clk;
   end

   // Main sequence
   initial begin
      cyc(6);
      i_sys_rst <= 1'b0;
      cyc(2);
      chk("discharge", 1, o_ss_discharge);
      chk("gates", 0, {o_ho, o_lo});
      chk("ref_scale", 32'h0000_03FF, o_ref_scale);
      rdm(`STC_ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
      rdm(`STC_ADDR_PER, 32'h0000_0064, 32'hFFFF_FFFF, 1'b0);
      wr(12'h010, 32'h0000_0001);
      rdm(12'h010, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
      v = $random(seed) & 32'h0000_FFFF;
      wr(`STC_ADDR_PER, v);
      rdm(`STC_ADDR_PER, v, 32'hFFFF_FFFF, 1'b0);
      wr(`STC_ADDR_PER, 32'h0000_0064);
      for (int m = 0; m < 4; m++) begin
         wr(`STC_ADDR_CTRL, 32'(m << 5));
         cyc(1);
         chk("drv_mode", m, o_drv_mode);
      end
      for (int sm = 0; sm < 3; sm++) begin
         wr(`STC_ADDR_CTRL, 32'(sm));
         cyc(1);
         chk("sync_oe", 32'(sm == 2), o_sync_oe);
         if (sm == 2) repeat (20) begin
            cyc(1);
            chk("sync_out", o_sw_clk, o_sync_o);
         end
      end
      wr(`STC_ADDR_CTRL, 32'h0000_0000);
      pins.en_ok <= 1'b1;
      pins.aux_ok <= 1'b1;
      pins.bst_ok <= 1'b1;
      mods.duty <= 8'($random(seed));
      cyc(250);
      chk("sw_en", 1, o_sw_en);
      chk("on_time", (32'h0000_0064 * mods.duty) >> 8, o_on_time);
      for (int c = 0; c < 5; c++) begin
         fault(c, 1'b1);
         cyc(8);
         chk("discharge", 1, o_ss_discharge);
         chk("sw_en", 0, o_sw_en);
         chk("use_ref", 0, o_ss_use_ref);
         fault(c, 1'b0);
         cyc(8);
         chk("restart", 1, o_sw_en);
      end
      pins.ss_above_ref <= 1'b1;
      cyc(8);
      chk("use_ref", 1, o_ss_use_ref);
      pins.ss_above_ref <= 1'b0;
      fault(2, 1'b1);
      cyc(8);
      fault(2, 1'b0);
      wr(`STC_ADDR_CTRL, 32'h0000_0100);
      pins.mode <= 1'b1;
      cyc(8);
      chk("track_start", 1, o_ss_use_ref);
      pins.bst_clamp <= 1'b1;
      cyc(8);
      chk("pulldown", 1, o_bst_pulldown);
      pins.bst_clamp <= 1'b0;
      cyc(8);
      chk("pulldown", 0, o_bst_pulldown);
      for (int x = 0; x < 3; x++) begin
         if (x == 2) wr(`STC_ADDR_PER, `STC_FAST_PER);
         wr(`STC_ADDR_CTRL, 32'(x << 3));
         dt_exp = (x == 2) ? 2 : 3 + x;
         repeat (8) begin
            mods.pwm_hi <= 2'($random(seed));
            cyc(25);
         end
      end
      wr(`STC_ADDR_PER, 32'h0000_0064);
      mods.pwm_hi <= 2'b11;
      cyc(25);
      mods.buck <= 1'b1;
      mods.pwm_hi <= 2'b00;
      cyc(25);
      chk("buck_hold", 1, o_ho[1]);
      mods.buck <= 1'b0;
      mods.boost <= 1'b1;
      cyc(25);
      chk("boost_hold", 1, o_ho[0]);
      mods.boost <= 1'b0;
      cyc(25);
      stuck <= 1'b1;
      mods.pwm_hi <= 2'b11;
      cyc(30);
      chk("gate_wait", 0, o_ho);
      stuck <= 1'b0;
      mods.pwm_hi <= 2'b00;
      wr(`STC_ADDR_CTRL, 32'h0000_0004);
      sync_per <= 16'h0082;
      cyc(2700);
      rdm(`STC_ADDR_STAT, 32'h0000_0018, 32'h0000_0018, 1'b0);
      s = sw_edges;
      cyc(1300);
      chk("sync_freq", 1, 32'((sw_edges - s) inside {[9:11]}));
      pins.psm <= 1'b1;
      cyc(8);
      rdm(`STC_ADDR_STAT, 32'h0000_0000, 32'h0000_0010, 1'b0);
      pins.psm <= 1'b0;
      cyc(600);
      rdm(`STC_ADDR_STAT, 32'h0000_0010, 32'h0000_0010, 1'b0);
      sync_per <= 16'h0028;
      cyc(300);
      chk("buf_en", 0, o_sync_buf_en);
      wr(`STC_ADDR_CTRL, 32'h0000_0001);
      sync_per <= 16'h0064;
      cyc(2700);
      rdm(`STC_ADDR_STAT, 32'h0000_0018, 32'h0000_0018, 1'b0);
      sync_per <= 16'h0000;
      trk_per <= 16'h0032;
      trk_hi <= 16'h000F;
      cyc(2100);
      chk("ref_scale", 32'h0000_03FF, o_ref_scale);
      pins.pwm_tracking_input_above <= 1'b1;
      cyc(2100);
      chk("ref_scale", 1, 32'(o_ref_scale inside {[291:323]}));
      trk_per <= 16'h03E8;
      trk_hi <= 16'h012C;
      cyc(2100);
      chk("ref_scale", 32'h0000_03FF, o_ref_scale);
      rdm(`STC_ADDR_STAT, 32'h0000_0002, 32'h0000_0006, 1'b0);
      pins.strap_dtx <= 1'b1;
      cyc(8);
      rdm(`STC_ADDR_STAT, 32'h0000_0002, 32'h0000_0006, 1'b0);
      pins.rst_pin <= 1'b1;
      cyc(8);
      pins.rst_pin <= 1'b0;
      cyc(8);
      rdm(`STC_ADDR_STAT, 32'h0000_0006, 32'h0000_0006, 1'b0);
      cyc(2);
      stop_test;
   end
   // Watchdog
   initial begin
      repeat (40000) @(posedge i_ref_clk);
      n_fail++;
      stop_test;
   end
endmodule // stc_top_tb
